// ==== flash_link_defs.svh ====
// timing constants and field widths for the serial flash link
`ifndef FLASH_LINK_DEFS_SVH
`define FLASH_LINK_DEFS_SVH
`define SYS_CLK_NS        8
`define WORD_BITS         8
`define CS_HIGH_NS        50
`define CS_HIGH_CYC       ((`CS_HIGH_NS + `SYS_CLK_NS - 1) / `SYS_CLK_NS)
`define WP_RESP_US        1
`define WP_RESP_CYC       ((`WP_RESP_US * 1000) / `SYS_CLK_NS)
`define DPD_ENTER_US      3
`define DPD_ENTER_CYC     ((`DPD_ENTER_US * 1000) / `SYS_CLK_NS)
`define DPD_EXIT_US       35
`define DPD_EXIT_CYC      ((`DPD_EXIT_US * 1000) / `SYS_CLK_NS)
`define XFER_US           200
`define XFER_CYC          ((`XFER_US * 1000) / `SYS_CLK_NS)
`define ERPG_MS           35
`define PGM_MS            4
`define ERASE_PG_MS       32
`define BLK_ERASE_MS      75
`define SECT_ERASE_MS     1300
`define CHIP_ERASE_MS     22000
`define MS_TO_CYC(m)      ((m) * (32'd1000000 / `SYS_CLK_NS))
`define RST_PULSE_US      10
`define RST_REC_US        1
`define OP_NONE           8'h00
`define OP_DPD            8'hb9
`define OP_RESUME         8'hab
`define OP_XFER           8'h53
`define OP_COMPARE        8'h60
`define OP_ERASE_PGM      8'h83
`define OP_PGM            8'h88
`define OP_PAGE_ERASE     8'h81
`define OP_BLK_ERASE      8'h50
`define OP_SECT_ERASE     8'h7c
`define OP_CHIP_ERASE     8'hc7
`endif

// ==== flash_link_pkg.sv ====
// state types for the serial flash link, one enum for each end
package flash_link_pkg;
   typedef enum logic [2:0] {
      st_idle = 3'b001,
      st_busy = 3'b010,
      st_dpd  = 3'b100
   } dev_state_type;
   typedef enum logic [3:0] {
      h_idle  = 4'b0001,
      h_setup = 4'b0010,
      h_shift = 4'b0100,
      h_gap   = 4'b1000
   } host_state_type;
endpackage : flash_link_pkg

// ==== flash_link_if.sv ====
// pins between the host controller and the serial flash end
`timescale 1ns/100ps
interface flash_link_if;
   logic sclk;
   logic cs_n;
   logic sdi;
   logic sdo;
   logic sdo_oe_n;
   logic wp_n;
   logic reset_n;
   modport host (output sclk, output cs_n, output sdi, output wp_n,
                 output reset_n, input sdo, input sdo_oe_n);
   modport mem (input sclk, input cs_n, input sdi, input wp_n,
                input reset_n, output sdo, output sdo_oe_n);
endinterface : flash_link_if

// ==== word_fifo.sv ====
// parameterised valid/ready fifo
`timescale 1ns/100ps
module word_fifo #(
   parameter int WIDTH = 8,
   parameter int DEPTH = 16
) (
   input  wire logic             sys_clk,
   input  wire logic             rstn,
   input  wire logic [WIDTH-1:0] in_data,
   input  wire logic             in_valid,
   output logic                  in_ready,
   output logic      [WIDTH-1:0] out_data,
   output logic                  out_valid,
   input  wire logic             out_ready
);
   localparam int AW = $clog2(DEPTH);
   initial if (DEPTH < 2 || (1 << AW) != DEPTH)
      $error("depth must be a power of two");
   logic [WIDTH-1:0] mem [DEPTH];
   logic [AW:0]      wr_ptr;
   logic [AW:0]      rd_ptr;
   logic [AW:0]      next_wr_ptr;
   logic [AW:0]      next_rd_ptr;
   logic             push;
   logic             pop;
   // flags from pointer distance
   assign in_ready  = (wr_ptr - rd_ptr) != (AW+1)'(DEPTH);
   assign out_valid = wr_ptr != rd_ptr;
   assign out_data  = mem[rd_ptr[AW-1:0]];
   assign push      = in_valid & in_ready;
   assign pop       = out_valid & out_ready;
   // pointer next values
   always_comb
   begin
      next_wr_ptr = push ? wr_ptr + 1'b1 : wr_ptr;
      next_rd_ptr = pop ? rd_ptr + 1'b1 : rd_ptr;
   end
   // pointers and storage
   always_ff @(posedge sys_clk)
   begin
      if (!rstn)
      begin
         wr_ptr <= '0;
         rd_ptr <= '0;
      end
      else
      begin
         wr_ptr <= next_wr_ptr;
         rd_ptr <= next_rd_ptr;
      end
      if (push)
         mem[wr_ptr[AW-1:0]] <= in_data;
   end
endmodule : word_fifo

// ==== flash_mem_end.sv ====
// serial flash end: pin sampling, byte shifting and operation timers
`include "flash_link_defs.svh"
`timescale 1ns/100ps
module flash_mem_end
   import flash_link_pkg::*;
#(
   parameter int WP_CYC   = `WP_RESP_CYC,
   parameter int DPDE_CYC = `DPD_ENTER_CYC,
   parameter int DPDX_CYC = `DPD_EXIT_CYC,
   parameter int XFR_CYC  = `XFER_CYC,
   parameter int ERPG_CYC = `MS_TO_CYC(`ERPG_MS),
   parameter int PGM_CYC  = `MS_TO_CYC(`PGM_MS),
   parameter int PER_CYC  = `MS_TO_CYC(`ERASE_PG_MS),
   parameter int BLK_CYC  = `MS_TO_CYC(`BLK_ERASE_MS),
   parameter int SECT_CYC = `MS_TO_CYC(`SECT_ERASE_MS),
   parameter int unsigned CHIP_CYC = `MS_TO_CYC(`CHIP_ERASE_MS)
) (
   input  wire logic       sys_clk,
   input  wire logic       rstn,
   flash_link_if.mem       link,
   output logic [7:0]      rx_data,
   output logic            rx_valid,
   input  wire logic [7:0] tx_data,
   output logic            tx_taken,
   output logic            busy,
   output logic            deep_pd,
   output logic            protected_on
);
   initial if (WP_CYC < 1 || DPDE_CYC < 1 || CHIP_CYC < 1)
      $error("timing counts must be at least one");
   // two-flop synchronisers for every pin
   logic [4:0] s1;
   logic [4:0] s2;
   logic [4:0] s3;
   logic sclk_rise;
   logic sclk_fall;
   logic cs_rise;
   logic cs_fall;
   always_ff @(posedge sys_clk)
   begin
      s1 <= {link.sclk, link.cs_n, link.sdi, link.wp_n, link.reset_n};
      s2 <= s1;
      s3 <= s2;
   end
   wire sclk_s = s2[4];
   wire cs_s   = s2[3];
   wire sdi_s  = s3[2]; // level just before the rise; host launches on it
   wire wp_s   = s2[1];
   wire prst_s = s2[0];
   assign sclk_rise = sclk_s & ~s3[4];
   assign sclk_fall = ~sclk_s & s3[4];
   assign cs_rise   = cs_s & ~s3[3];
   assign cs_fall   = ~cs_s & s3[3];
   wire   lrst      = ~rstn | ~prst_s;
   dev_state_type state;
   dev_state_type next_state;
   logic [2:0]  bit_cnt;
   logic [2:0]  next_bit_cnt;
   logic [7:0]  shin;
   logic [7:0]  next_shin;
   logic [7:0]  shout;
   logic [7:0]  next_shout;
   logic [7:0]  opcode;
   logic [7:0]  next_opcode;
   logic        first;
   logic        next_first;
   logic [31:0] timer;
   logic [31:0] next_timer;
   logic [31:0] wp_cnt;
   logic [31:0] next_wp_cnt;
   logic        next_sdo;
   logic        next_oe_n;
   logic        next_rx_valid;
   logic        next_tx_taken;
   logic        next_prot;
   // operation duration lookup
   function automatic logic [31:0] op_time(input logic [7:0] op);
      case (op)
         `OP_XFER:       op_time = 32'(XFR_CYC);
         `OP_COMPARE:    op_time = 32'(XFR_CYC);
         `OP_ERASE_PGM:  op_time = 32'(ERPG_CYC);
         `OP_PGM:        op_time = 32'(PGM_CYC);
         `OP_PAGE_ERASE: op_time = 32'(PER_CYC);
         `OP_BLK_ERASE:  op_time = 32'(BLK_CYC);
         `OP_SECT_ERASE: op_time = 32'(SECT_CYC);
         `OP_CHIP_ERASE: op_time = 32'(CHIP_CYC);
         default:        op_time = 32'h0000_0000;
      endcase
   endfunction : op_time

   // link and operation next values
   always_comb
   begin
      next_state    = state;
      next_bit_cnt  = bit_cnt;
      next_shin     = shin;
      next_shout    = shout;
      next_opcode   = opcode;
      next_first    = first;
      next_timer    = timer;
      next_sdo      = link.sdo;
      next_oe_n     = link.sdo_oe_n;
      next_rx_valid = 1'b0;
      next_tx_taken = 1'b0;
      if (cs_s)
      begin
         next_oe_n    = 1'b1;
         next_bit_cnt = 3'h0;
      end
      if (cs_fall)
      begin
         next_first = 1'b1;
         next_shout = tx_data;
         next_bit_cnt = 3'h0;
      end
      if (!cs_s && sclk_rise && state != st_busy)
      begin
         next_shin    = {shin[6:0], sdi_s};
         next_bit_cnt = bit_cnt + 3'h1;
         if (bit_cnt == 3'h7)
         begin
            next_rx_valid = 1'b1;
            if (first)
               next_opcode = {shin[6:0], sdi_s};
            next_first = 1'b0;
         end
      end
      // drive on falling edge, valid through clock low
      if (!cs_s && sclk_fall && state == st_idle)
      begin
         next_sdo   = shout[7];
         next_oe_n  = 1'b0;
         next_shout = {shout[6:0], 1'b0};
         if (bit_cnt == 3'h0)
         begin
            next_sdo      = tx_data[7];
            next_shout    = {tx_data[6:0], 1'b0};
            next_tx_taken = 1'b1;
         end
      end
      case (state)
         st_idle:
            if (cs_rise && op_time(opcode) != 32'h0)
            begin
               next_state = st_busy;
               next_timer = op_time(opcode);
            end
            else if (cs_rise && opcode == `OP_DPD)
            begin
               next_state = st_dpd;
               next_timer = 32'(DPDE_CYC);
            end
         st_busy:
            if (timer <= 32'h1)
            begin
               next_state = st_idle;
               next_timer = 32'h0;
            end
            else
               next_timer = timer - 32'h1;
         st_dpd:
         begin
            if (timer != 32'h0)
               next_timer = timer - 32'h1;
            if (cs_rise && opcode == `OP_RESUME)
            begin
               next_state = st_busy;
               next_timer = 32'(DPDX_CYC);
            end
         end
         default: next_state = st_idle;
      endcase
      if (cs_rise)
         next_opcode = `OP_NONE;
   end

   always_comb
   begin
      next_prot   = protected_on;
      next_wp_cnt = 32'h0;
      if (wp_s == protected_on)
      begin
         next_wp_cnt = wp_cnt + 32'h1;
         if (wp_cnt + 32'h1 >= 32'(WP_CYC))
         begin
            next_prot   = ~wp_s;
            next_wp_cnt = 32'h0;
         end
      end
   end
   // state registers
   always_ff @(posedge sys_clk)
   begin
      if (lrst)
      begin
         state        <= st_idle;
         bit_cnt      <= 3'h0;
         shin         <= 8'h00;
         shout        <= 8'h00;
         opcode       <= 8'h00;
         first        <= 1'b0;
         timer        <= 32'h0;
         link.sdo     <= 1'b0;
         link.sdo_oe_n <= 1'b1;
         rx_data      <= 8'h00;
         rx_valid     <= 1'b0;
         tx_taken     <= 1'b0;
         busy         <= 1'b0;
         deep_pd      <= 1'b0;
      end
      else
      begin
         state        <= next_state;
         bit_cnt      <= next_bit_cnt;
         shin         <= next_shin;
         shout        <= next_shout;
         opcode       <= next_opcode;
         first        <= next_first;
         timer        <= next_timer;
         link.sdo     <= next_sdo;
         link.sdo_oe_n <= next_oe_n;
         rx_data      <= next_rx_valid ? next_shin : rx_data;
         rx_valid     <= next_rx_valid;
         tx_taken     <= next_tx_taken;
         busy         <= next_state == st_busy;
         deep_pd      <= next_state == st_dpd && next_timer == 32'h0;
      end
   end

   // protection register, reset only by system reset
   always_ff @(posedge sys_clk)
   begin
      if (!rstn)
      begin
         protected_on <= 1'b0;
         wp_cnt       <= 32'h0;
      end
      else
      begin
         protected_on <= next_prot;
         wp_cnt       <= next_wp_cnt;
      end
   end
endmodule : flash_mem_end

// ==== flash_host_end.sv ====
// host controller end: clock divider, framing and byte fifo
`include "flash_link_defs.svh"
`timescale 1ns/100ps
module flash_host_end
   import flash_link_pkg::*;
#(
   parameter int DIV       = 8,
   parameter int GAP_CYC   = `CS_HIGH_CYC,
   parameter int RST_CYC   = (`RST_PULSE_US * 1000) / `SYS_CLK_NS,
   parameter int REC_CYC   = (`RST_REC_US * 1000) / `SYS_CLK_NS,
   parameter int FIFO_DEPTH = 16
) (
   input  wire logic       sys_clk,
   input  wire logic       rstn,
   flash_link_if.host      link,
   input  wire logic [7:0] tx_data,
   input  wire logic       tx_valid,
   output logic            tx_ready,
   input  wire logic       tx_last,
   output logic [7:0]      rx_data,
   output logic            rx_valid,
   input  wire logic       wp_req_n,
   output logic            ready
);
   // divider sets link clock to 125/DIV MHz, 125/8 MHz at the default DIV of 8
   initial if (DIV < 4 || DIV % 2 != 0)
      $error("divider must be even and at least 4");
   logic [8:0] f_out;
   logic       f_valid;
   logic       f_pop;
   word_fifo #(.WIDTH(9), .DEPTH(FIFO_DEPTH)) u_fifo (
      .sys_clk   (sys_clk),
      .rstn      (rstn),
      .in_data   ({tx_last, tx_data}),
      .in_valid  (tx_valid),
      .in_ready  (tx_ready),
      .out_data  (f_out),
      .out_valid (f_valid),
      .out_ready (f_pop)
   );
   logic so1;
   logic so2;
   always_ff @(posedge sys_clk)
   begin
      so1 <= link.sdo;
      so2 <= so1;
   end
   host_state_type state;
   host_state_type next_state;
   logic [15:0] div_cnt;
   logic [15:0] next_div_cnt;
   logic [2:0]  bits;
   logic [2:0]  next_bits;
   logic [7:0]  sh;
   logic [7:0]  next_sh;
   logic [7:0]  rsh;
   logic [7:0]  next_rsh;
   logic        last;
   logic        next_last;
   logic [15:0] rcnt;
   logic [15:0] next_rcnt;
   logic        next_sclk;
   logic        next_cs_n;
   logic        next_sdi;
   logic        next_rst_n;
   logic        next_rx_valid;
   logic        next_ready;
   wire  half = div_cnt == 16'(DIV/2 - 1);
   assign f_pop = state == h_setup && f_valid;
   // framing next values
   always_comb
   begin
      next_state    = state;
      next_div_cnt  = div_cnt;
      next_bits     = bits;
      next_sh       = sh;
      next_rsh      = rsh;
      next_last     = last;
      next_rcnt     = rcnt;
      next_sclk     = link.sclk;
      next_cs_n     = link.cs_n;
      next_sdi      = link.sdi;
      next_rst_n    = link.reset_n;
      next_rx_valid = 1'b0;
      next_ready    = ready;
      // reset pulse with select high, then recovery
      if (rcnt != 16'h0)
      begin
         next_rcnt  = rcnt - 16'h1;
         next_cs_n  = 1'b1;
         if (rcnt == 16'(REC_CYC + 1))
            next_rst_n = 1'b1;
         next_ready = rcnt == 16'h1;
      end
      else
      case (state)
         h_idle:
            if (f_valid)
               next_state = h_setup;
         h_setup:
         begin
            next_cs_n    = 1'b0;
            next_sh      = f_out[7:0];
            next_last    = f_out[8];
            next_bits    = 3'h0;
            next_div_cnt = 16'h0;
            next_state   = h_shift;
            next_sdi     = f_out[7];
         end
         h_shift:
         begin
            next_div_cnt = half ? 16'h0 : div_cnt + 16'h1;
            if (half)
               next_sclk = ~link.sclk;
            // capture at falling, launch at rising
            if (half && link.sclk)
            begin
               next_rsh  = {rsh[6:0], so2};
               next_bits = bits + 3'h1;
               if (bits == 3'h7)
               begin
                  next_rx_valid = 1'b1;
                  next_state    = last ? h_gap : (f_valid ? h_setup : h_gap);
                  next_last     = 1'b1;
               end
            end
            if (half && !link.sclk)
            begin
               next_sh  = {sh[6:0], 1'b0};
               next_sdi = sh[6];
            end
         end
         h_gap:
         begin
            next_cs_n    = 1'b1;
            next_div_cnt = div_cnt + 16'h1;
            if (div_cnt >= 16'(GAP_CYC))
               next_state = h_idle;
         end
         default: next_state = h_idle;
      endcase
      if (state == h_setup && !link.cs_n)
         next_cs_n = 1'b0;
      if (state == h_idle)
         next_div_cnt = 16'h0;
   end
   // state registers
   always_ff @(posedge sys_clk)
   begin
      if (!rstn)
      begin
         state        <= h_idle;
         div_cnt      <= 16'h0;
         bits         <= 3'h0;
         sh           <= 8'h00;
         rsh          <= 8'h00;
         last         <= 1'b0;
         rcnt         <= 16'(RST_CYC + REC_CYC);
         link.sclk    <= 1'b0;
         link.cs_n    <= 1'b1;
         link.sdi     <= 1'b0;
         link.reset_n <= 1'b0;
         link.wp_n    <= 1'b1;
         rx_data      <= 8'h00;
         rx_valid     <= 1'b0;
         ready        <= 1'b0;
      end
      else
      begin
         state        <= next_state;
         div_cnt      <= next_div_cnt;
         bits         <= next_bits;
         sh           <= next_sh;
         rsh          <= next_rsh;
         last         <= next_last;
         rcnt         <= next_rcnt;
         link.sclk    <= next_sclk;
         link.cs_n    <= next_cs_n;
         link.sdi     <= next_sdi;
         link.reset_n <= next_rst_n;
         link.wp_n    <= wp_req_n;
         rx_data      <= next_rx_valid ? next_rsh : rx_data;
         rx_valid     <= next_rx_valid;
         ready        <= next_ready;
      end
   end
endmodule : flash_host_end

// ==== flash_link_checker.sv ====
// interface-level assertions for the serial flash link
`timescale 1ns/100ps
module flash_link_checker #(
   parameter int GAP_CYC = 7,
   parameter int RST_CYC = 4,
   parameter int REC_CYC = 4
) (
   input wire logic sys_clk,
   input wire logic rstn,
   input wire logic sclk,
   input wire logic cs_n,
   input wire logic sdi,
   input wire logic sdo,
   input wire logic sdo_oe_n,
   input wire logic wp_n,
   input wire logic reset_n
);
   logic [7:0] hi_cnt;
   logic [7:0] lo_cnt;
   logic [7:0] rec_cnt;
   // saturating counts: cs high, reset low, time since reset release
   always_ff @(posedge sys_clk)
   begin
      if (!rstn)
      begin
         hi_cnt  <= 8'h00;
         lo_cnt  <= 8'h00;
         rec_cnt <= 8'h00;
      end
      else
      begin
         hi_cnt  <= !cs_n ? 8'h00 : hi_cnt + {7'h00, hi_cnt != 8'hff};
         lo_cnt  <= reset_n ? lo_cnt : lo_cnt + {7'h00, lo_cnt != 8'hff};
         rec_cnt <= !reset_n ? 8'h00 : rec_cnt + {7'h00, rec_cnt != 8'hff};
      end
   end
   default clocking cb @(posedge sys_clk); endclocking
   default disable iff (!rstn);
   a_cs_gap_min: assert property ($fell(cs_n) |-> hi_cnt >= GAP_CYC)
      else $error("chip select high gap too short");
   a_sclk_high_min: assert property ($rose(sclk) |-> sclk [*2])
      else $error("serial clock high phase too short");
   a_sclk_low_min: assert property ($fell(sclk) |-> (!sclk) [*2])
      else $error("serial clock low phase too short");
   a_reset_cs_high: assert property ($rose(reset_n) |-> cs_n)
      else $error("reset released with chip select low");
   a_reset_pulse_width: assert property (
      $rose(reset_n) |-> lo_cnt >= RST_CYC - 1)
      else $error("reset pulse too short");
   a_recovery_wait: assert property ($fell(cs_n) |-> rec_cnt >= REC_CYC)
      else $error("command started during reset recovery");
   a_sdo_clock_low: assert property (
      !sdo_oe_n && $past(!sdo_oe_n) && $changed(sdo) |-> !sclk)
      else $error("serial output changed while clock high");
   // input launched at clock rise or while low, never while high or at fall
   a_sdi_hold_high: assert property ($past(sclk) && !cs_n |-> $stable(sdi))
      else $error("serial input moved outside a clock rise");
   a_sdo_release: assert property ($rose(cs_n) |-> ##[0:4] sdo_oe_n)
      else $error("serial output not released after frame");
   // clock idles while deselected; output settles after its release
   a_sclk_idle: assert property (cs_n && $past(cs_n) |-> $stable(sclk) &&
      (hi_cnt < 8'h04 || $stable(sdo_oe_n)))
      else $error("serial clock moved while deselected");
   c_frame: cover property ($fell(cs_n));
   c_sdo_move: cover property (!sdo_oe_n && $changed(sdo));
   c_reset_done: cover property ($rose(reset_n));
   c_wp_low: cover property ($fell(wp_n));
endmodule : flash_link_checker

// ==== serial_flash_link_timing_test.sv ====
// self-checking bench joining host and flash ends
`include "flash_link_defs.svh"
`timescale 1ns/100ps
module serial_flash_link_timing_test import flash_link_pkg::*; ;
   localparam int GAP = 7;
   localparam int RSTC = 4;
   localparam int RECC = 4;
   localparam int WPC = 20;
   localparam int DPDE = 24;
   localparam int DPDX = 28;
   localparam logic [7:0] OPS [8] = '{`OP_XFER, `OP_COMPARE, `OP_ERASE_PGM,
      `OP_PGM, `OP_PAGE_ERASE, `OP_BLK_ERASE, `OP_SECT_ERASE, `OP_CHIP_ERASE};
   localparam int CYC [8] = '{30, 30, 34, 36, 38, 40, 42, 44}; // shared xfer
   logic       sys_clk = 1'b0;
   logic       rstn = 1'b0;
   logic [7:0] h_tx_data = 8'h00;
   logic       h_tx_valid = 1'b0;
   logic       h_tx_last = 1'b0;
   logic       wp_req_n = 1'b1;
   logic [7:0] m_tx_data = 8'ha5;
   logic       h_tx_ready, h_rx_valid, ready, m_rx_valid;
   logic       busy, deep_pd, protected_on, m_tx_taken;
   logic [7:0] h_rx_data, m_rx_data;
   logic [7:0] m_q [$];
   logic [7:0] h_q [$];
   int         bad_count = 0;
   int         checks_done = 0;
   int         taken_n = 0;
   always #4 sys_clk = ~sys_clk;
   flash_link_if i_flash_link_if ();
   flash_host_end #(.DIV(8), .GAP_CYC(GAP), .RST_CYC(RSTC), .REC_CYC(RECC),
      .FIFO_DEPTH(16)) i_flash_host_end (.sys_clk(sys_clk), .rstn(rstn),
      .link(i_flash_link_if), .tx_data(h_tx_data), .tx_valid(h_tx_valid),
      .tx_ready(h_tx_ready), .tx_last(h_tx_last), .rx_data(h_rx_data),
      .rx_valid(h_rx_valid), .wp_req_n(wp_req_n), .ready(ready));
   flash_mem_end #(.WP_CYC(WPC), .DPDE_CYC(DPDE), .DPDX_CYC(DPDX),
      .XFR_CYC(CYC[0]), .ERPG_CYC(CYC[2]), .PGM_CYC(CYC[3]), .PER_CYC(CYC[4]),
      .BLK_CYC(CYC[5]), .SECT_CYC(CYC[6]), .CHIP_CYC(CYC[7]))
      i_flash_mem_end (.sys_clk(sys_clk), .rstn(rstn), .link(i_flash_link_if),
      .rx_data(m_rx_data), .rx_valid(m_rx_valid), .tx_data(m_tx_data),
      .tx_taken(m_tx_taken), .busy(busy), .deep_pd(deep_pd),
      .protected_on(protected_on));
   flash_link_checker #(.GAP_CYC(GAP), .RST_CYC(RSTC), .REC_CYC(RECC))
      i_flash_link_checker (.sys_clk(sys_clk), .rstn(rstn),
      .sclk(i_flash_link_if.sclk), .cs_n(i_flash_link_if.cs_n),
      .sdi(i_flash_link_if.sdi), .sdo(i_flash_link_if.sdo),
      .sdo_oe_n(i_flash_link_if.sdo_oe_n), .wp_n(i_flash_link_if.wp_n),
      .reset_n(i_flash_link_if.reset_n));
   // capture received bytes mid-cycle on both user sides
   always @(negedge sys_clk)
   begin
      if (m_rx_valid === 1'b1) m_q.push_back(m_rx_data);
      if (h_rx_valid === 1'b1) h_q.push_back(h_rx_data);
      if (m_tx_taken === 1'b1) taken_n++;
   end
   task automatic tick();
      @(posedge sys_clk);
      #1;
   endtask : tick
   task automatic check_bit(input string what, input logic e, input logic g);
      checks_done++;
      if (g !== e)
      begin
         bad_count++;
         $display("MISMATCH %s expected %b seen %b", what, e, g);
      end
   endtask : check_bit
   task automatic check_byte(input string what, input logic [7:0] e,
                             input logic [7:0] g);
      checks_done++;
      if (g !== e)
      begin
         bad_count++;
         $display("MISMATCH %s expected %h seen %h", what, e, g);
      end
   endtask : check_byte
   task automatic check_span(input string what, input int lo, input int hi,
                             input int g);
      checks_done++;
      if (g < lo || g > hi)
      begin
         bad_count++;
         $display("MISMATCH %s expected %0d..%0d seen %0d", what, lo, hi, g);
      end
   endtask : check_span
   function automatic logic flag(input int sel);
      case (sel)
         0: return busy;
         1: return deep_pd;
         2: return protected_on;
         default: return ready;
      endcase
   endfunction : flag
   // counts cycles until the chosen flag reaches the level
   task automatic wait_flag(input int sel, input logic lvl, output int n);
      n = 0;
      while (flag(sel) !== lvl && n < 5000)
      begin
         n++;
         tick();
      end
   endtask : wait_flag
   // holds valid until a ready edge takes the byte; n counts refused cycles
   task automatic send_byte(input logic [7:0] d, input logic last, output int n);
      h_tx_data = d;
      h_tx_last = last;
      h_tx_valid = 1'b1;
      n = 0;
      while (h_tx_ready !== 1'b1 && n < 5000)
      begin
         n++;
         tick();
      end
      tick();
   endtask : send_byte
   task automatic wait_cs_end();
      int n;
      n = 0;
      while (i_flash_link_if.cs_n !== 1'b0 && n < 5000) begin n++; tick(); end
      while (i_flash_link_if.cs_n !== 1'b1 && n < 5000) begin n++; tick(); end
      check_bit("frame end", 1'b1, i_flash_link_if.cs_n);
   endtask : wait_cs_end
   task automatic send_op(input logic [7:0] op);
      int n;
      send_byte(op, 1'b1, n);
      h_tx_valid = 1'b0;
      h_tx_last = 1'b0;
      wait_cs_end();
   endtask : send_op
   task automatic test_reset();
      int n;
      check_bit("cs_n in reset", 1'b1, i_flash_link_if.cs_n);
      check_bit("sdo_oe_n in reset", 1'b1, i_flash_link_if.sdo_oe_n);
      check_bit("busy in reset", 1'b0, busy);
      check_bit("protect in reset", 1'b0, protected_on);
      rstn = 1'b1;
      wait_flag(3, 1'b1, n);
      check_span("ready delay", RSTC + RECC - 1, RSTC + RECC + 3, n);
      $display("test reset done");
   endtask : test_reset
   task automatic test_fill();
      int n;
      int first;
      first = -1;
      m_q.delete();
      taken_n = 0;
      h_q.delete();
      for (int i = 0; i < 20; i++)
      begin
         send_byte(8'(i * 37), i == 19, n);
         if (n > 0 && first < 0) first = i;
      end
      h_tx_valid = 1'b0;
      h_tx_last = 1'b0;
      wait_cs_end();
      repeat (8) tick();
      check_span("first refused byte", 16, 18, first);
      check_bit("tx_ready drained", 1'b1, h_tx_ready);
      check_span("flash rx count", 20, 20, m_q.size());
      check_span("host rx count", 20, 20, h_q.size());
      check_span("tx_taken count", 20, 20, taken_n);
      for (int i = 0; i < m_q.size() && i < 20; i++)
         check_byte("flash rx byte", 8'(i * 37), m_q[i]);
      for (int i = 1; i < h_q.size(); i++)
         check_byte("host rx byte", 8'ha5, h_q[i]);
      $display("test fill done");
   endtask : test_fill
   task automatic test_ops();
      int n;
      for (int k = 0; k < 8; k++)
      begin
         send_op(OPS[k]);
         wait_flag(0, 1'b1, n);
         check_span("busy start", 0, 6, n);
         wait_flag(0, 1'b0, n);
         check_span("busy length", CYC[k], CYC[k] + 2, n);
      end
      $display("test ops done");
   endtask : test_ops
   task automatic test_dpd();
      int n;
      send_op(`OP_DPD);
      wait_flag(1, 1'b1, n);
      check_span("power-down entry", DPDE - 2, DPDE + 5, n);
      send_op(`OP_RESUME);
      wait_flag(0, 1'b1, n);
      check_span("resume start", 0, 6, n);
      wait_flag(0, 1'b0, n);
      check_span("resume length", DPDX, DPDX + 2, n);
      check_bit("standby reached", 1'b0, deep_pd);
      $display("test dpd done");
   endtask : test_dpd
   task automatic test_wp();
      int n;
      wp_req_n = 1'b0;
      wait_flag(2, 1'b1, n);
      check_span("protect on delay", WPC, WPC + 5, n);
      check_bit("wp_n on link", 1'b0, i_flash_link_if.wp_n);
      wp_req_n = 1'b1;
      wait_flag(2, 1'b0, n);
      check_span("protect off delay", WPC, WPC + 5, n);
      $display("test wp done");
   endtask : test_wp
   task automatic close_out();
      $display("checks %0d mismatches %0d", checks_done, bad_count);
      if (bad_count == 0 && checks_done > 0)
         $display("Run complete: PASS");
      else
         $display("Run complete: FAIL");
      $finish;
   endtask : close_out
   // main sequence
   initial
   begin
      repeat (5) tick();
      test_reset();
      test_fill();
      test_ops();
      test_dpd();
      test_wp();
      close_out();
   end
   // watchdog well beyond the expected run
   initial
   begin
      #200000;
      bad_count++;
      close_out();
   end
endmodule : serial_flash_link_timing_test
